//--- core/pl_top.sv
// Purpose: patch trigger and signature registers of the processor core
// Assumes: core issues model-register accesses and identification pulses
//          on CLK_SYS; decryption lives outside this block
// Notes:   RST is the hard reset; SOFT_INIT is the processor init
module pl_top
    import pl_pkg::*;
#(
    parameter int PAYLOAD_BYTES = PL_PAYLOAD_BYTES
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        SOFT_INIT,
    input  wire logic        MR_WR,
    input  wire logic        MR_RD,
    input  wire logic [31:0] MR_INDEX,
    input  wire logic [63:0] MR_WDATA,
    output logic [63:0]      MR_RDATA,
    output logic             MR_RVALID,
    input  wire logic        ID_EXEC,
    output logic             MEM_REQ,
    output logic [31:0]      MEM_ADDR,
    input  wire logic        MEM_ACK,
    input  wire logic [7:0]  MEM_RDATA,
    output logic [7:0]       PATCH_BYTE,
    output logic             PATCH_BYTE_VALID,
    output logic             PATCH_BYTE_LAST,
    input  wire logic        DEC_DONE,
    input  wire logic        DEC_OK,
    input  wire logic [31:0] DEC_REV,
    output logic             PATCH_ACTIVE,
    output logic             LOAD_BUSY
);
    pl_eng_if eng ();

    logic        start;
    logic [31:0] base_addr;
    logic [31:0] active_rev;
    logic [63:0] signature;
    logic        trigger_hit;

    assign trigger_hit = MR_WR && (MR_INDEX == PL_IDX_TRIGGER)
                         && (MR_WDATA[63:32] == 32'h0000_0000);

    // request toward the fetcher; a trigger while busy is dropped, so
    // repeated loads can never interleave two payloads
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            start     <= 1'b0;
            base_addr <= 32'h0000_0000;
        end else begin
            start <= trigger_hit && !eng.busy && !start && !SOFT_INIT;
            if (trigger_hit) begin
                base_addr <= MR_WDATA[31:0];
            end
        end
    end
    assign eng.start     = start;
    assign eng.base_addr = base_addr;

    // active patch state: only hard reset clears it
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            PATCH_ACTIVE <= 1'b0;
            active_rev   <= 32'h0000_0000;
        end else if (eng.done && eng.ok) begin
            PATCH_ACTIVE <= 1'b1;
            active_rev   <= eng.rev;
        end
    end

    // signature register: firmware writes, identification deposits
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            signature <= PL_SIG_RESET;
        end else if (MR_WR && (MR_INDEX == PL_IDX_SIGNATURE)) begin
            signature <= MR_WDATA;
        end else if (ID_EXEC && PATCH_ACTIVE) begin
            signature <= {active_rev, 32'h0000_0000};
        end
    end

    // read path; reads have no side effects on the patch
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            MR_RDATA  <= 64'h0000_0000_0000_0000;
            MR_RVALID <= 1'b0;
        end else begin
            MR_RVALID <= MR_RD;
            if (MR_RD && (MR_INDEX == PL_IDX_SIGNATURE)) begin
                MR_RDATA <= signature;
            end else if (MR_RD) begin
                MR_RDATA <= 64'h0000_0000_0000_0000;
            end
        end
    end

    // busy flag is the fetcher busy or a pending start, registered for the port
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            LOAD_BUSY <= 1'b0;
        end else begin
            LOAD_BUSY <= eng.busy || start;
        end
    end

    pl_fetch #(
        .PAYLOAD_BYTES (PAYLOAD_BYTES)
    ) u_fetch (
        .clk        (CLK_SYS),
        .rst        (RST),
        .soft_init  (SOFT_INIT),
        .eng        (eng.eng),
        .mem_req    (MEM_REQ),
        .mem_addr   (MEM_ADDR),
        .mem_ack    (MEM_ACK),
        .mem_rdata  (MEM_RDATA),
        .byte_data  (PATCH_BYTE),
        .byte_valid (PATCH_BYTE_VALID),
        .byte_last  (PATCH_BYTE_LAST),
        .dec_done   (DEC_DONE),
        .dec_ok     (DEC_OK),
        .dec_rev    (DEC_REV)
    );
endmodule

//--- core/pl_pkg.sv
// Summary of operation
// - load starts on model-register write to 79h with high data zero.
// - payload fetched bytewise, so any start address is accepted.
// - hard reset discards the active patch; firmware reloads it.
// - soft init keeps the active patch in effect.
// - repeated triggers of the same patch cause no harm.
// - no patch needed for self test; no load timing constraint.
// - identification instruction deposits active patch id into 08Bh.
// - with no patch active, identification leaves 08Bh unchanged.
// - reading 08Bh returns active revision in upper 32-bit half.
// - signature equals header revision; reading never disturbs the patch.
//
// Purpose: constants shared by the patch load and signature block
// Assumes: one core clock, model-register port driven by the core
// Notes:   indices are model-register numbers, not byte addresses
package pl_pkg;
    localparam logic [31:0] PL_IDX_TRIGGER   = 32'h0000_0079;
    localparam logic [31:0] PL_IDX_SIGNATURE = 32'h0000_008b;
    localparam logic [63:0] PL_SIG_RESET     = 64'h0000_0000_0000_0000;
    localparam int          PL_BLOCK_BYTES   = 2048;
    localparam int          PL_HEADER_BYTES  = 48;
    localparam int          PL_PAYLOAD_BYTES =
        PL_BLOCK_BYTES - PL_HEADER_BYTES;
    localparam int          PL_REV_LSB       = 32;
endpackage

//--- core/pl_eng_if.sv
// Purpose: carries a load request and its outcome between top and fetcher
// Assumes: all signals on CLK_SYS
// Notes:   start and done are one-cycle pulses
interface pl_eng_if;
    logic        start;
    logic [31:0] base_addr;
    logic        busy;
    logic        done;
    logic        ok;
    logic [31:0] rev;
    modport ctrl (output start, output base_addr,
                  input busy, input done, input ok, input rev);
    modport eng  (input start, input base_addr,
                  output busy, output done, output ok, output rev);
endinterface

//--- core/pl_fetch.sv
// Purpose: walks the payload byte by byte and hands it to the decryptor
// Assumes: memory answers one byte per acknowledged request
// Notes:   soft init aborts a load in flight without touching the patch
module pl_fetch
    import pl_pkg::*;
#(
    parameter int PAYLOAD_BYTES = PL_PAYLOAD_BYTES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        soft_init,
    pl_eng_if.eng            eng,
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [7:0]  mem_rdata,
    output logic [7:0]       byte_data,
    output logic             byte_valid,
    output logic             byte_last,
    input  wire logic        dec_done,
    input  wire logic        dec_ok,
    input  wire logic [31:0] dec_rev
);
    typedef enum logic [1:0] {S_IDLE, S_FETCH, S_WAIT} pl_fstate_type;

    pl_fstate_type state;
    logic [15:0]   count;
    logic          last_byte;

    assign last_byte = (count == 16'(PAYLOAD_BYTES - 1));
    assign eng.busy  = (state != S_IDLE);

    // sequencer: fetch every payload byte, then wait for the verdict
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= S_IDLE;
            count    <= 16'h0000;
            mem_req  <= 1'b0;
            mem_addr <= 32'h0000_0000;
        end else if (soft_init) begin
            state    <= S_IDLE;
            mem_req  <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (eng.start) begin
                        state    <= S_FETCH;
                        count    <= 16'h0000;
                        mem_addr <= eng.base_addr;
                        mem_req  <= 1'b1;
                    end
                end
                S_FETCH: begin
                    if (mem_ack) begin
                        mem_addr <= mem_addr + 32'h0000_0001;
                        count    <= count + 16'h0001;
                        if (last_byte) begin
                            state   <= S_WAIT;
                            mem_req <= 1'b0;
                        end
                    end
                end
                S_WAIT: begin
                    if (dec_done) begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // byte stream toward the decryptor, one pulse per acknowledged byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            byte_data  <= 8'h00;
            byte_valid <= 1'b0;
            byte_last  <= 1'b0;
        end else begin
            byte_valid <= (state == S_FETCH) && mem_ack && !soft_init;
            byte_last  <= (state == S_FETCH) && mem_ack && last_byte
                          && !soft_init;
            if ((state == S_FETCH) && mem_ack) begin
                byte_data <= mem_rdata;
            end
        end
    end

    // outcome pulse back to the control side
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eng.done <= 1'b0;
            eng.ok   <= 1'b0;
            eng.rev  <= 32'h0000_0000;
        end else begin
            eng.done <= (state == S_WAIT) && dec_done && !soft_init;
            if ((state == S_WAIT) && dec_done) begin
                eng.ok  <= dec_ok;
                eng.rev <= dec_rev;
            end
        end
    end
endmodule

//--- verification/pl_chk_sva.sv
// Purpose: port-level property checks for the patch load block
// Assumes: one clock, RST asynchronous and active high
// Notes:   soft init guards keep fetch aborts out of the fetch checks
module pl_chk
    import pl_pkg::*;
(
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        SOFT_INIT,
    input wire logic        MR_WR,
    input wire logic        MR_RD,
    input wire logic [31:0] MR_INDEX,
    input wire logic [63:0] MR_WDATA,
    input wire logic        MR_RVALID,
    input wire logic        MEM_REQ,
    input wire logic [31:0] MEM_ADDR,
    input wire logic        MEM_ACK,
    input wire logic [7:0]  MEM_RDATA,
    input wire logic [7:0]  PATCH_BYTE,
    input wire logic        PATCH_BYTE_VALID,
    input wire logic        DEC_DONE,
    input wire logic        DEC_OK,
    input wire logic        PATCH_ACTIVE,
    input wire logic        LOAD_BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // accepted trigger on an idle block, not aborted next cycle
    sequence s_trig;
        MR_WR && MR_INDEX == PL_IDX_TRIGGER && MR_WDATA[63:32] == 32'h0
            && !LOAD_BUSY && !MEM_REQ && !SOFT_INIT ##1 !SOFT_INIT;
    endsequence
    sequence s_take;
        MEM_REQ && MEM_ACK && !SOFT_INIT;
    endsequence
    property p_start;
        s_trig |-> ##1 (MEM_REQ && MEM_ADDR == $past(MR_WDATA[31:0], 2));
    endproperty
    a_start: assert property (p_start) else $error("load start wrong");
    property p_reject;
        MR_WR && MR_INDEX == PL_IDX_TRIGGER && MR_WDATA[63:32] != 32'h0
            && !LOAD_BUSY && !MEM_REQ |-> ##2 !MEM_REQ;
    endproperty
    a_reject: assert property (p_reject) else $error("bad trigger ran");
    property p_addr;
        s_take |=> !MEM_REQ || MEM_ADDR == $past(MEM_ADDR) + 32'h1;
    endproperty
    a_addr: assert property (p_addr) else $error("fetch address skip");
    property p_byte;
        s_take |=> PATCH_BYTE_VALID && PATCH_BYTE == $past(MEM_RDATA);
    endproperty
    a_byte: assert property (p_byte) else $error("byte not passed on");
    property p_rd;
        MR_RD |=> MR_RVALID;
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_rv;
        MR_RVALID |-> $past(MR_RD);
    endproperty
    a_rv: assert property (p_rv) else $error("stray read valid");
    property p_soft;
        SOFT_INIT && !LOAD_BUSY |=> $stable(PATCH_ACTIVE);
    endproperty
    a_soft: assert property (p_soft) else $error("init lost patch");
    property p_fail;
        DEC_DONE && !DEC_OK |-> ##2 PATCH_ACTIVE == $past(PATCH_ACTIVE, 2);
    endproperty
    a_fail: assert property (p_fail) else $error("failed load changed");
    property p_ok;
        DEC_DONE && DEC_OK && LOAD_BUSY && !MEM_REQ && !SOFT_INIT
            |-> ##2 PATCH_ACTIVE;
    endproperty
    a_ok: assert property (p_ok) else $error("good load not active");
    // hard reset must hold everything clear, so no disable here
    property p_rst;
        disable iff (1'b0) RST |-> !PATCH_ACTIVE && !LOAD_BUSY && !MEM_REQ;
    endproperty
    a_rst: assert property (p_rst) else $error("reset kept patch");
endmodule
bind pl_top pl_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .SOFT_INIT(SOFT_INIT), .MR_WR(MR_WR), .MR_RD(MR_RD),
    .MR_INDEX(MR_INDEX), .MR_WDATA(MR_WDATA), .MR_RVALID(MR_RVALID),
    .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK),
    .MEM_RDATA(MEM_RDATA), .PATCH_BYTE(PATCH_BYTE),
    .PATCH_BYTE_VALID(PATCH_BYTE_VALID), .DEC_DONE(DEC_DONE),
    .DEC_OK(DEC_OK), .PATCH_ACTIVE(PATCH_ACTIVE), .LOAD_BUSY(LOAD_BUSY));

//--- verification/pl_top_tb.sv
// Purpose: directed test of patch trigger and signature registers
// Assumes: memory acks every cycle, verdict driven by hand
// Notes:   payload cut to 8 bytes so each load stays short
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module pl_top_tb
    import pl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 8;
    logic        CLK_SYS = 0, RST = 0, SOFT_INIT = 0, ID_EXEC = 0;
    logic        MR_WR = 0, MR_RD = 0, MEM_ACK = 0, DEC_DONE = 0;
    logic        DEC_OK = 0, MR_RVALID, MEM_REQ, PATCH_ACTIVE, LOAD_BUSY;
    logic        PATCH_BYTE_VALID, PATCH_BYTE_LAST;
    logic [31:0] MR_INDEX = 0, DEC_REV = 0, MEM_ADDR;
    logic [63:0] MR_WDATA = 0, MR_RDATA;
    logic [7:0]  MEM_RDATA = 0, PATCH_BYTE;
    int          bad_count = 0, total_checks = 0, nbytes = 0;
    pl_top #(.PAYLOAD_BYTES(P)) uut (.*);
    always #5 CLK_SYS = ~CLK_SYS;
    // memory model: byte value is the low address byte, acked at once
    always @(posedge CLK_SYS) begin
        #1;
        MEM_ACK = MEM_REQ;
        MEM_RDATA = MEM_ADDR[7:0];
    end
    // count on the falling edge, where the byte pulse has settled
    always @(negedge CLK_SYS) if (PATCH_BYTE_VALID === 1'b1) nbytes++;
    task automatic tick;
        @(posedge CLK_SYS);
        #1;
    endtask
    task automatic wr(input logic [31:0] i, input logic [63:0] d);
        MR_WR = 1;
        MR_INDEX = i;
        MR_WDATA = d;
        tick;
        MR_WR = 0;
    endtask
    task automatic rd(input logic [31:0] i, input logic [63:0] e);
        MR_RD = 1;
        MR_INDEX = i;
        tick;
        MR_RD = 0;
        `CHK("rvalid", 1'b1, MR_RVALID)
        `CHK("rdata", e, MR_RDATA)
    endtask
    // zero the signature, identify, read back
    // zero identify read
    task automatic sig(input logic [63:0] e);
        wr(PL_IDX_SIGNATURE, 64'h0);
        ID_EXEC = 1;
        tick;
        ID_EXEC = 0;
        rd(PL_IDX_SIGNATURE, e);
    endtask
    task automatic load(input logic [31:0] a, input logic ok,
                        input logic [31:0] rev);
        int n;
        nbytes = 0;
        n = 0;
        wr(PL_IDX_TRIGGER, {32'h0, a});
        while (PATCH_BYTE_LAST !== 1'b1 && n < 50) begin
            tick;
            n++;
        end
        `CHK("last_seen", 1'b1, PATCH_BYTE_LAST)
        `CHK("last_byte", 8'(a[7:0] + 8'(P - 1)), PATCH_BYTE)
        DEC_DONE = 1;
        DEC_OK = ok;
        DEC_REV = rev;
        tick;
        DEC_DONE = 0;
        tick;
        tick;
        `CHK("byte_count", P, nbytes)
    endtask
    task automatic conclude;
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #50000;
        bad_count++;
        conclude;
    end
    initial begin
        // raise reset after time zero so the design sees a real edge
        #1 RST = 1;
        repeat (3) @(posedge CLK_SYS);
        #1 RST = 0;
        tick;
        `CHK("active_reset", 1'b0, PATCH_ACTIVE)
        wr(PL_IDX_SIGNATURE, 64'h5a5a_0000_0000_1111);
        ID_EXEC = 1;
        tick;
        ID_EXEC = 0;
        rd(PL_IDX_SIGNATURE, 64'h5a5a_0000_0000_1111);
        rd(32'h0000_0010, 64'h0);
        wr(PL_IDX_TRIGGER, {32'h1, 32'h0000_1003});
        tick;
        tick;
        `CHK("busy_reject", 1'b0, LOAD_BUSY)
        load(32'h0000_1003, 1'b1, 32'h0000_0010);
        `CHK("active", 1'b1, PATCH_ACTIVE)
        sig({32'h0000_0010, 32'h0});
        load(32'h0000_1003, 1'b1, 32'h0000_0010);
        sig({32'h0000_0010, 32'h0});
        load(32'h0000_2001, 1'b0, 32'h0000_0011);
        sig({32'h0000_0010, 32'h0});
        SOFT_INIT = 1;
        tick;
        SOFT_INIT = 0;
        sig({32'h0000_0010, 32'h0});
        // soft init in mid fetch abandons the load, keeps the patch
        wr(PL_IDX_TRIGGER, {32'h0, 32'h0000_3000});
        tick;
        tick;
        SOFT_INIT = 1;
        tick;
        SOFT_INIT = 0;
        tick;
        tick;
        `CHK("abort_busy", 1'b0, LOAD_BUSY)
        `CHK("abort_active", 1'b1, PATCH_ACTIVE)
        sig({32'h0000_0010, 32'h0});
        RST = 1;
        tick;
        RST = 0;
        tick;
        `CHK("active_hard", 1'b0, PATCH_ACTIVE)
        sig(64'h0);
        conclude;
    end
endmodule
